// ### src/gpio_port.sv
// General-purpose I/O port with AXI4-Lite register access and an input synchroniser.
//
// Operation
// R1: Direction bit set or cleared alone.
// R2: Single drive or pull-up bit changes alone.
// R3: Three port locations: output, direction, input.
// R4: Input register read-only; others read/write.
// R5: Writing one to input toggles output.
// R6: Global pull-up disable kills every pull-up.
// R7: Each pin has its own pull-up.
// R8: Alternate pins leave others as I/O.
// R9: Latch on low clock, then rising edge.
// R10: Pin change visible after half to 1.5 periods.
// R11: Own driven value synchronises in one period.
// R12: Software waits one idle slot before readback.
// R13: Direction one drives, zero leaves undriven.
// R14: Pull-up only for input, data one, enabled.
`include "gpio_port_cfg.svh"
`default_nettype none

module gpio_port #(
    parameter int WIDTH = 8,
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk, // System clock, 250 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [WIDTH-1:0] pin_in, // Pad input levels.
    output logic [WIDTH-1:0] pin_out, // Pad output levels.
    output logic [WIDTH-1:0] pin_oe_n, // Pad output enables, low while driving.
    output logic [WIDTH-1:0] pullup_en, // Pad pull-up enables, high active.
    input wire logic [WIDTH-1:0] alt_enable, // Peripheral takes over the pin.
    input wire logic [WIDTH-1:0] alt_out, // Peripheral output level.
    input wire logic [WIDTH-1:0] alt_drive // Peripheral drives the pin.
);

    // Register state.
    logic [WIDTH-1:0] output_data_reg_q;
    logic [WIDTH-1:0] output_data_reg_d;
    logic [WIDTH-1:0] pin_direction_reg_q;
    logic [WIDTH-1:0] pin_direction_reg_d;
    logic pullup_global_disable_q;
    logic pullup_global_disable_d;
    logic [WIDTH-1:0] pin_input_reg;

    // Pad drive state.
    logic [WIDTH-1:0] pin_out_q;
    logic [WIDTH-1:0] pin_oe_n_q;
    logic [WIDTH-1:0] pullup_en_q;

    // Bus state.
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [WIDTH-1:0] wdata_q;
    logic wlane_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Write channel handshakes.
    wire aw_take = s_axi_awvalid && awready_q;
    wire w_take = s_axi_wvalid && wready_q;
    wire aw_held = !awready_q;
    wire w_held = !wready_q;
    wire do_write = aw_held && w_held && !bvalid_q;
    wire b_done = bvalid_q && s_axi_bready;

    // Read channel handshakes.
    wire ar_take = s_axi_arvalid && arready_q;
    wire r_done = rvalid_q && s_axi_rready;

    // Address decode, shared by both directions.
    function automatic gpio_port_pkg::reg_sel_type decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] low;
        logic high_zero;
        low = addr[7:0];
        high_zero = (addr >> 8) == '0;
        decode = gpio_port_pkg::SEL_NONE;
        if (high_zero) begin
            case (low)
                `OFS_OUTPUT_DATA: decode = gpio_port_pkg::SEL_OUTPUT;
                `OFS_PIN_DIRECTION: decode = gpio_port_pkg::SEL_DIRECTION;
                `OFS_PIN_INPUT: decode = gpio_port_pkg::SEL_INPUT;
                `OFS_MCU_CONTROL: decode = gpio_port_pkg::SEL_CONTROL;
                `OFS_OUTPUT_SET: decode = gpio_port_pkg::SEL_OUT_SET;
                `OFS_OUTPUT_CLEAR: decode = gpio_port_pkg::SEL_OUT_CLR;
                `OFS_DIRECTION_SET: decode = gpio_port_pkg::SEL_DIR_SET;
                `OFS_DIRECTION_CLEAR: decode = gpio_port_pkg::SEL_DIR_CLR;
                default: decode = gpio_port_pkg::SEL_NONE;
            endcase
        end
    endfunction

    wire gpio_port_pkg::reg_sel_type wsel = decode(awaddr_q);
    wire gpio_port_pkg::reg_sel_type rsel = decode(s_axi_araddr);
    wire wr_ok = do_write && (wsel != gpio_port_pkg::SEL_NONE);
    // Registers are one byte wide, so only lane 0 carries data; other lanes are accepted and dropped.
    wire wr_en = wr_ok && wlane_q;

    wire wr_output = wr_en && (wsel == gpio_port_pkg::SEL_OUTPUT);
    wire wr_direction = wr_en && (wsel == gpio_port_pkg::SEL_DIRECTION);
    wire wr_toggle = wr_en && (wsel == gpio_port_pkg::SEL_INPUT);
    wire wr_control = wr_en && (wsel == gpio_port_pkg::SEL_CONTROL);
    wire wr_out_set = wr_en && (wsel == gpio_port_pkg::SEL_OUT_SET);
    wire wr_out_clr = wr_en && (wsel == gpio_port_pkg::SEL_OUT_CLR);
    wire wr_dir_set = wr_en && (wsel == gpio_port_pkg::SEL_DIR_SET);
    wire wr_dir_clr = wr_en && (wsel == gpio_port_pkg::SEL_DIR_CLR);

    // Next output data: whole write, toggle, or bitwise set and clear masks.
    assign output_data_reg_d = wr_output ? wdata_q : // [R2]
                               wr_toggle ? (output_data_reg_q ^ wdata_q) : // [R5]
                               wr_out_set ? (output_data_reg_q | wdata_q) : // [R2]
                               wr_out_clr ? (output_data_reg_q & ~wdata_q) : // [R2]
                               output_data_reg_q;

    // Next direction: a whole write, or a set or clear mask in which only bits written as one move.
    assign pin_direction_reg_d = wr_direction ? wdata_q :
                                 wr_dir_set ? (pin_direction_reg_q | wdata_q) : // [R1]
                                 wr_dir_clr ? (pin_direction_reg_q & ~wdata_q) : // [R1]
                                 pin_direction_reg_q;

    // The disable bit is kept in its own flip-flop, caught from write data bit 4 when the write data is taken.
    logic pud_bit_q;
    assign pullup_global_disable_d = wr_control ? pud_bit_q : pullup_global_disable_q; // [R6]

    // Pad control, per pin; a peripheral owns only the pins it has enabled.
    wire [WIDTH-1:0] drive_sel = (alt_enable & alt_drive) | (~alt_enable & pin_direction_reg_q); // [R8] [R13]
    wire [WIDTH-1:0] level_sel = (alt_enable & alt_out) | (~alt_enable & output_data_reg_q); // [R8]
    wire [WIDTH-1:0] pullup_sel = ~drive_sel & output_data_reg_q & {WIDTH{!pullup_global_disable_q}}; // [R6] [R7] [R14]

    // Read data mux.
    wire [WIDTH-1:0] rd_byte = (rsel == gpio_port_pkg::SEL_OUTPUT) ? output_data_reg_q :
                               (rsel == gpio_port_pkg::SEL_OUT_SET) ? output_data_reg_q :
                               (rsel == gpio_port_pkg::SEL_OUT_CLR) ? output_data_reg_q :
                               (rsel == gpio_port_pkg::SEL_DIRECTION) ? pin_direction_reg_q :
                               (rsel == gpio_port_pkg::SEL_DIR_SET) ? pin_direction_reg_q :
                               (rsel == gpio_port_pkg::SEL_DIR_CLR) ? pin_direction_reg_q :
                               (rsel == gpio_port_pkg::SEL_INPUT) ? pin_input_reg : // [R3] [R4]
                               '0;
    wire [31:0] rd_ctrl = 32'(pullup_global_disable_q) << `PULLUP_DISABLE_POS;
    wire [31:0] rd_word = (rsel == gpio_port_pkg::SEL_CONTROL) ? rd_ctrl : 32'(rd_byte);
    wire [1:0] rd_resp = (rsel == gpio_port_pkg::SEL_NONE) ? gpio_port_pkg::RESP_SLVERR : gpio_port_pkg::RESP_OKAY;
    wire [1:0] wr_resp = wr_ok ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;

    // A pin that this port drives is synchronised from its own registered driven level, so the input register follows an output data write two periods later.
    wire [WIDTH-1:0] sync_level = (drive_sel & pin_out_q) | (~drive_sel & pin_in); // [R11]

    pin_input_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .level_in(sync_level),
        .sync_out(pin_input_reg)
    );

    // Port registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            output_data_reg_q <= `RST_OUTPUT_DATA;
            pin_direction_reg_q <= `RST_PIN_DIRECTION;
            pullup_global_disable_q <= `RST_PULLUP_DISABLE;
        end else begin
            output_data_reg_q <= output_data_reg_d;
            pin_direction_reg_q <= pin_direction_reg_d;
            pullup_global_disable_q <= pullup_global_disable_d;
        end
    end

    // Pad drivers; registered so that every pad output comes from a flip-flop.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_out_q <= '0;
            pin_oe_n_q <= '1;
            pullup_en_q <= '0;
        end else begin
            pin_out_q <= level_sel; // [R13]
            pin_oe_n_q <= ~drive_sel; // [R13]
            pullup_en_q <= pullup_sel; // [R14]
        end
    end

    // Write address and data are caught in either order; the response follows once both are held.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awready_q <= 1'h1;
            awaddr_q <= '0;
        end else if (aw_take) begin
            awready_q <= 1'h0;
            awaddr_q <= s_axi_awaddr;
        end else if (b_done) begin
            awready_q <= 1'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wready_q <= 1'h1;
            wdata_q <= '0;
            wlane_q <= 1'h0;
            pud_bit_q <= 1'h0;
        end else if (w_take) begin
            wready_q <= 1'h0;
            wdata_q <= s_axi_wdata[WIDTH-1:0];
            wlane_q <= s_axi_wstrb[0];
            pud_bit_q <= s_axi_wdata[`PULLUP_DISABLE_POS];
        end else if (b_done) begin
            wready_q <= 1'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bvalid_q <= 1'h0;
            bresp_q <= gpio_port_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'h1;
            bresp_q <= wr_resp;
        end else if (b_done) begin
            bvalid_q <= 1'h0;
        end
    end

    // Reads: address taken, data answered on the next edge, next address only after the data is taken.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arready_q <= 1'h1;
            rvalid_q <= 1'h0;
            rresp_q <= gpio_port_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else if (ar_take) begin
            arready_q <= 1'h0;
            rvalid_q <= 1'h1;
            rresp_q <= rd_resp;
            rdata_q <= rd_word;
        end else if (r_done) begin
            arready_q <= 1'h1;
            rvalid_q <= 1'h0;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;
    assign pullup_en = pullup_en_q;

endmodule // gpio_port

`default_nettype wire

// ### src/gpio_port_cfg.svh
// Register offsets, field positions and reset values of the general-purpose I/O port.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

`define OFS_OUTPUT_DATA 8'h00
`define OFS_PIN_DIRECTION 8'h04
`define OFS_PIN_INPUT 8'h08
`define OFS_MCU_CONTROL 8'h0c
`define OFS_OUTPUT_SET 8'h10
`define OFS_OUTPUT_CLEAR 8'h14
`define OFS_DIRECTION_SET 8'h18
`define OFS_DIRECTION_CLEAR 8'h1c

`define PULLUP_DISABLE_POS 4

`define RST_OUTPUT_DATA 8'h00
`define RST_PIN_DIRECTION 8'h00
`define RST_PULLUP_DISABLE 1'h0

`endif

// ### src/gpio_port_pkg.sv
// Shared types of the general-purpose I/O port.
`default_nettype none

package gpio_port_pkg;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_type;

    typedef enum logic [7:0] {
        SEL_NONE = 8'h00,
        SEL_OUTPUT = 8'h01,
        SEL_DIRECTION = 8'h02,
        SEL_INPUT = 8'h04,
        SEL_CONTROL = 8'h08,
        SEL_OUT_SET = 8'h10,
        SEL_OUT_CLR = 8'h20,
        SEL_DIR_SET = 8'h40,
        SEL_DIR_CLR = 8'h80
    } reg_sel_type;

endpackage

`default_nettype wire

// ### src/gpio_port_tail_note.sv
// Intentionally empty compilation unit kept out: see main file.

// ### src/pin_input_sync.sv
// Two-stage pin synchroniser: a falling-edge catch stage followed by the rising-edge pin input register.
`default_nettype none

module pin_input_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [WIDTH-1:0] level_in, // Level to be synchronised.
    output logic [WIDTH-1:0] sync_out // Synchronised level.
);

    logic [WIDTH-1:0] catch_q;
    logic [WIDTH-1:0] hold_q;

    // The catch stage closes on the falling edge, so it stands for the latch that is open while the clock is high.
    always_ff @(negedge sys_clk) begin
        if (rst) begin
            catch_q <= '0;
        end else begin
            catch_q <= level_in; // [R9]
        end
    end

    // A change is seen here between half a period and one and a half periods after it arrives.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_q <= '0;
        end else begin
            hold_q <= catch_q; // [R9] [R10]
        end
    end

    assign sync_out = hold_q;

endmodule // pin_input_sync

`default_nettype wire

// ### tb/gpio_port_sva.sv
// Bus and pad checks for the I/O port.
`default_nettype none

module gpio_port_sva #(
    parameter int WIDTH = 8,
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk, input wire logic rst,
    input wire logic s_axi_awvalid, input wire logic s_axi_awready,
    input wire logic s_axi_wvalid, input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp, input wire logic s_axi_bvalid, input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr, input wire logic s_axi_arvalid, input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata, input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid, input wire logic s_axi_rready,
    input wire logic [WIDTH-1:0] pin_oe_n, input wire logic [WIDTH-1:0] pullup_en
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_write_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:8] != '0
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    a_pullup_input: assert property ((pullup_en & ~pin_oe_n) == '0)
        else $error("pull-up on a driven pin");
    a_reset_state: assert property (@(posedge sys_clk) disable iff (1'b0) rst
        |=> !s_axi_bvalid && !s_axi_rvalid && &pin_oe_n && pullup_en == '0) else $error("reset state wrong");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_pullup: cover property (|pullup_en);
endmodule // gpio_port_sva

bind gpio_port gpio_port_sva #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) u_gpio_port_sva (
    .sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en));

`default_nettype wire

// ### tb/pin_board.sv
// Board-side model of the port pins: pad drivers, pull-ups and an external source.
`default_nettype none

module pin_board #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk, // System clock.
    input wire logic [WIDTH-1:0] pin_out, // Pad output levels.
    input wire logic [WIDTH-1:0] pin_oe_n, // Pad enables, low while driving.
    input wire logic [WIDTH-1:0] pullup_en, // Pull-up enables.
    input wire logic [WIDTH-1:0] ext_level, // External source level.
    input wire logic [WIDTH-1:0] ext_en, // External source drives the pin.
    output logic [WIDTH-1:0] pin_level // Resolved wire level.
);
    logic [WIDTH-1:0] float_q = '0;

    // An undriven pin without pull-up floats, so it must never read as a steady value.
    always_ff @(posedge sys_clk) begin
        float_q <= ~float_q;
    end

    assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_level)
        | (pin_oe_n & ~ext_en & (pullup_en | float_q));
endmodule // pin_board

`default_nettype wire

// ### tb/tb.sv
// Register and pad testbench for the I/O port.
`include "gpio_port_cfg.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en;
    logic [7:0] alt_enable = 8'h0, alt_out = 8'h0, alt_drive = 8'h0, ext_level = 8'h0, ext_en = 8'h0;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 sys_clk = ~sys_clk;

    gpio_port #(.WIDTH(8), .ADDR_W(12)) u_gpio_port (.sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .alt_enable(alt_enable), .alt_out(alt_out), .alt_drive(alt_drive));

    pin_board #(.WIDTH(8)) u_pin_board (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .ext_level(ext_level), .ext_en(ext_en), .pin_level(pin_in));

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge sys_clk);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge sys_clk);
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask

    // The ceiling is well above the hundred or so cycles the sequence needs.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd({4'h0, `OFS_OUTPUT_DATA}, {24'h0, `RST_OUTPUT_DATA}, 2'h0);
        rd({4'h0, `OFS_PIN_DIRECTION}, {24'h0, `RST_PIN_DIRECTION}, 2'h0);
        rd({4'h0, `OFS_MCU_CONTROL}, 32'h0, 2'h0);
        wr({4'h0, `OFS_OUTPUT_DATA}, 32'ha5, 2'h0);
        wr({4'h0, `OFS_PIN_DIRECTION}, 32'h0f, 2'h0);
        rd({4'h0, `OFS_OUTPUT_DATA}, 32'ha5, 2'h0);
        wr({4'h0, `OFS_DIRECTION_SET}, 32'h10, 2'h0);
        rd({4'h0, `OFS_PIN_DIRECTION}, 32'h1f, 2'h0);
        wr({4'h0, `OFS_DIRECTION_CLEAR}, 32'h01, 2'h0);
        rd({4'h0, `OFS_PIN_DIRECTION}, 32'h1e, 2'h0);
        wr({4'h0, `OFS_OUTPUT_SET}, 32'h02, 2'h0);
        wr({4'h0, `OFS_OUTPUT_CLEAR}, 32'h80, 2'h0);
        rd({4'h0, `OFS_OUTPUT_DATA}, 32'h27, 2'h0);
        wr({4'h0, `OFS_PIN_INPUT}, 32'h0c, 2'h0);
        rd({4'h0, `OFS_OUTPUT_DATA}, 32'h2b, 2'h0);
        wr(12'h020, 32'hff, 2'h2);
        rd(12'h100, 32'h0, 2'h2);
        rd({4'h0, `OFS_OUTPUT_DATA}, 32'h2b, 2'h0);
        repeat (2) @(posedge sys_clk);
        chk("pin_oe_n", 32'he1, {24'h0, pin_oe_n});
        chk("pin_out", 32'h2b, {24'h0, pin_out});
        chk("pullup_en", 32'h21, {24'h0, pullup_en});
        ext_en <= 8'hff;
        ext_level <= 8'h40;
        repeat (2) @(posedge sys_clk);
        rd({4'h0, `OFS_PIN_INPUT}, 32'h4a, 2'h0);
        wr({4'h0, `OFS_MCU_CONTROL}, 32'h10, 2'h0);
        repeat (2) @(posedge sys_clk);
        chk("pullup_en", 32'h0, {24'h0, pullup_en});
        rd({4'h0, `OFS_MCU_CONTROL}, 32'h10, 2'h0);
        wr({4'h0, `OFS_OUTPUT_DATA}, 32'h14, 2'h0);
        @(posedge sys_clk);
        rd({4'h0, `OFS_PIN_INPUT}, 32'h54, 2'h0);
        alt_enable <= 8'h80;
        alt_drive <= 8'h80;
        alt_out <= 8'h80;
        repeat (2) @(posedge sys_clk);
        chk("pin_oe_n", 32'h61, {24'h0, pin_oe_n});
        chk("pin_out", 32'h94, {24'h0, pin_out});
        end_of_test();
    end
endmodule // tb

`default_nettype wire
